/* File: dbp_sram_port.sv */
/*
 * Two-word burst DDR SRAM port: link pin sampling, burst counter,
 * byte write selects, posted writes, read bypass, output pipeline and
 * an Avalon-MM register slave.
 * Assumes link clocks far slower than i_clock (125 ns vs 10 ns).
 */
`default_nettype none

// Function
// - With PLL enabled, first read word follows command by one and half cycles.
// - With PLL disabled, read data follows command by one cycle.
// - Every access starts at a positive input clock rise.
// - Write data is captured on both input clock rises.
// - Direction and load strobe sampled only at positive clock rise; byte selects at both rises.
// - Outputs timed from output clocks, or input clocks in single clock mode.
// - Each access moves two sequential 18-bit words.
// - Read address is stored; its lowest bit feeds the burst counter.
// - Burst counter steps the address linearly for the second word.
// - With PLL enabled, first read word appears on negative output clock after next rise.
// - With PLL enabled, second read word appears on following positive output clock rise.
// - A new read command is accepted at every positive rise.
// - Deselected reads finish, then outputs float after next output clock rise.
// - Two write words at next rise and next negative rise form 36 bits.
// - A write command is accepted at every positive rise.
// - Deselected writes finish pending data phases, then inputs are ignored.
// - Byte selects are sampled with each write word.
// - Deasserted byte select leaves that stored byte unchanged.
// - Write after read is posted and committed at the next write.
// - Read of just written address returns posted data.
module dbp_sram_port
    import dbp_pkg::*;
#(
    parameter int P_ADDR_W = ADDR_W
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_k,
    input  wire logic                 i_k_n,
    input  wire logic                 i_c,
    input  wire logic                 i_c_n,
    input  wire logic                 i_pll_disable_n,
    input  wire logic                 i_dir_read,
    input  wire logic                 i_load_strobe_n,
    input  wire logic [NUM_BYTES-1:0] i_byte_write_select_n,
    input  wire logic [P_ADDR_W-1:0]  i_addr,
    input  wire logic [DATA_W-1:0]    i_d,
    output var  logic [DATA_W-1:0]    o_q,
    output var  logic                 o_q_oe,
    input  wire logic [AVS_AW-1:0]    i_avs_address,
    input  wire logic                 i_avs_read,
    input  wire logic                 i_avs_write,
    input  wire logic [AVS_DW-1:0]    i_avs_writedata,
    input  wire logic [3:0]           i_avs_byteenable,
    output var  logic [AVS_DW-1:0]    o_avs_readdata,
    output var  logic                 o_avs_waitrequest
);
    localparam int PIN_W = 9 + NUM_BYTES + P_ADDR_W + DATA_W - 2;
    localparam int DEPTH = 2 ** P_ADDR_W;

    // Pin synchronisers
    logic [PIN_W-1:0] pin_s1_r;
    logic [PIN_W-1:0] pin_s2_r;
    logic [3:0]       clk_d_r;
    logic             k_s, kn_s, c_s, cn_s, dll_s, dir_s, load_n_s;
    logic [1:0]       bsel_n_s;
    logic [P_ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0]   d_s;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            clk_d_r  <= '0;
        end else begin
            pin_s1_r <= {i_k, i_k_n, i_c, i_c_n, i_pll_disable_n, i_dir_read,
                         i_load_strobe_n, i_byte_write_select_n, i_addr, i_d};
            pin_s2_r <= pin_s1_r;
            clk_d_r  <= pin_s2_r[PIN_W-1 -: 4];
        end
    end

    assign {k_s, kn_s, c_s, cn_s, dll_s, dir_s, load_n_s, bsel_n_s, addr_s,
            d_s} = pin_s2_r;

    // Edges count only once both stages hold real pin values
    logic [1:0] strap_cnt_r, strap_cnt_nxt;
    logic       sync_ok;
    logic k_rise, kn_rise, c_rise, cn_rise;
    assign sync_ok = (strap_cnt_r == STRAP_DONE);
    assign k_rise  = k_s  & ~clk_d_r[3] & sync_ok;
    assign kn_rise = kn_s & ~clk_d_r[2] & sync_ok;
    assign c_rise  = c_s  & ~clk_d_r[1] & sync_ok;
    assign cn_rise = cn_s & ~clk_d_r[0] & sync_ok;

    // Strap catch and mode edges
    logic       single_r, single_nxt;
    logic       oclk_rise, oclkn_rise, ev_first, ev_second;

    always_comb begin
        strap_cnt_nxt = strap_cnt_r;
        single_nxt    = single_r;
        if (strap_cnt_r != STRAP_DONE) begin
            strap_cnt_nxt = strap_cnt_r + 2'h1;
        end
        if (strap_cnt_r == STRAP_AT) begin
            single_nxt = c_s & cn_s;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            strap_cnt_r <= '0;
            single_r    <= 1'b0;
        end else begin
            strap_cnt_r <= strap_cnt_nxt;
            single_r    <= single_nxt;
        end
    end

    assign oclk_rise  = single_r ? k_rise  : c_rise;
    assign oclkn_rise = single_r ? kn_rise : cn_rise;
    assign ev_first   = dll_s ? oclkn_rise : oclk_rise;
    assign ev_second  = dll_s ? oclk_rise  : oclkn_rise;

    // Command decode, sampled only at positive input rise
    logic ctrl_en_r, ctrl_en_nxt;
    logic cmd, rd_cmd, wr_cmd;
    assign cmd    = k_rise & ~load_n_s & ctrl_en_r;
    assign rd_cmd = cmd & dir_s;
    assign wr_cmd = cmd & ~dir_s;

    // Storage
    logic [DATA_W-1:0] mem [DEPTH];

    function automatic logic [DATA_W-1:0] lane_en(input logic [1:0] m);
        lane_en = {{BYTE_W{m[1]}}, {BYTE_W{m[0]}}};
    endfunction

    // Write path
    logic                wr_pend_r, wr_pend_nxt;
    logic [P_ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
    logic                wd_v_r, wd_v_nxt;
    logic [P_ADDR_W-1:0] wd_addr_r, wd_addr_nxt;
    logic [DATA_W-1:0]   wd_w0_r, wd_w0_nxt;
    logic [1:0]          wd_m0_r, wd_m0_nxt;
    logic                post_v_r, post_v_nxt;
    logic [P_ADDR_W-1:0] post_addr_r, post_addr_nxt;
    logic [DATA_W-1:0]   post_w0_r, post_w0_nxt, post_w1_r, post_w1_nxt;
    logic [1:0]          post_m0_r, post_m0_nxt, post_m1_r, post_m1_nxt;
    logic                commit;

    assign commit = kn_rise & wd_v_r & post_v_r;

    always_comb begin
        wr_pend_nxt   = wr_pend_r;
        wr_addr_nxt   = wr_addr_r;
        wd_v_nxt      = wd_v_r;
        wd_addr_nxt   = wd_addr_r;
        wd_w0_nxt     = wd_w0_r;
        wd_m0_nxt     = wd_m0_r;
        post_v_nxt    = post_v_r;
        post_addr_nxt = post_addr_r;
        post_w0_nxt   = post_w0_r;
        post_w1_nxt   = post_w1_r;
        post_m0_nxt   = post_m0_r;
        post_m1_nxt   = post_m1_r;
        if (k_rise) begin
            wr_pend_nxt = wr_cmd;
            if (wr_cmd) begin
                wr_addr_nxt = addr_s;
            end
            wd_v_nxt    = wr_pend_r;
            wd_addr_nxt = wr_addr_r;
            wd_w0_nxt   = d_s;
            wd_m0_nxt   = ~bsel_n_s;
        end else if (kn_rise && wd_v_r) begin
            wd_v_nxt      = 1'b0;
            post_v_nxt    = 1'b1;
            post_addr_nxt = wd_addr_r;
            post_w0_nxt   = wd_w0_r;
            post_m0_nxt   = wd_m0_r;
            post_w1_nxt   = d_s;
            post_m1_nxt   = ~bsel_n_s;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= '0;
            wd_v_r      <= 1'b0;
            wd_addr_r   <= '0;
            wd_w0_r     <= '0;
            wd_m0_r     <= '0;
            post_v_r    <= 1'b0;
            post_addr_r <= '0;
            post_w0_r   <= '0;
            post_w1_r   <= '0;
            post_m0_r   <= '0;
            post_m1_r   <= '0;
        end else begin
            wr_pend_r   <= wr_pend_nxt;
            wr_addr_r   <= wr_addr_nxt;
            wd_v_r      <= wd_v_nxt;
            wd_addr_r   <= wd_addr_nxt;
            wd_w0_r     <= wd_w0_nxt;
            wd_m0_r     <= wd_m0_nxt;
            post_v_r    <= post_v_nxt;
            post_addr_r <= post_addr_nxt;
            post_w0_r   <= post_w0_nxt;
            post_w1_r   <= post_w1_nxt;
            post_m0_r   <= post_m0_nxt;
            post_m1_r   <= post_m1_nxt;
        end
    end

    // Array commit keeps unselected bytes
    logic [P_ADDR_W-1:0] post_addr1;
    assign post_addr1 = {post_addr_r[P_ADDR_W-1:1], ~post_addr_r[0]};

    always_ff @(posedge i_clock) begin
        if (commit) begin
            mem[post_addr_r] <= (mem[post_addr_r] & ~lane_en(post_m0_r))
                              | (post_w0_r & lane_en(post_m0_r));
            mem[post_addr1]  <= (mem[post_addr1] & ~lane_en(post_m1_r))
                              | (post_w1_r & lane_en(post_m1_r));
        end
    end

    // Array read with posted-write bypass
    function automatic logic [DATA_W-1:0] rd_word(input logic [P_ADDR_W-1:0] a);
        logic [DATA_W-1:0] w;
        w = mem[a];
        if (post_v_r && a == post_addr_r) begin
            w = (w & ~lane_en(post_m0_r)) | (post_w0_r & lane_en(post_m0_r));
        end
        if (post_v_r && a == post_addr1) begin
            w = (w & ~lane_en(post_m1_r)) | (post_w1_r & lane_en(post_m1_r));
        end
        rd_word = w;
    endfunction

    // Read path and output pipeline
    logic                rd_pend_r, rd_pend_nxt;
    logic [P_ADDR_W-1:0] rd_addr_r, rd_addr_nxt;
    logic                slot_v_r, slot_v_nxt;
    logic [P_ADDR_W-1:0] slot_addr_r, slot_addr_nxt;
    logic [P_ADDR_W-1:0] sec_addr_r, sec_addr_nxt;
    dbp_out_state_t      out_st_r, out_st_nxt;
    logic [DATA_W-1:0]   q_nxt;
    logic                oe_nxt, avail, fire;
    logic [P_ADDR_W-1:0] src_addr;

    assign avail    = slot_v_r | (k_rise & rd_pend_r);
    assign src_addr = slot_v_r ? slot_addr_r : rd_addr_r;
    assign fire     = (out_st_r == OUT_IDLE) & avail & ev_first;

    always_comb begin
        rd_pend_nxt   = rd_pend_r;
        rd_addr_nxt   = rd_addr_r;
        slot_v_nxt    = slot_v_r;
        slot_addr_nxt = slot_addr_r;
        sec_addr_nxt  = sec_addr_r;
        out_st_nxt    = out_st_r;
        q_nxt         = o_q;
        oe_nxt        = o_q_oe;
        if (k_rise) begin
            rd_pend_nxt = rd_cmd;
            if (rd_cmd) begin
                rd_addr_nxt = addr_s;
            end
        end
        if (fire) begin
            if (slot_v_r) begin
                slot_v_nxt    = k_rise & rd_pend_r;
                slot_addr_nxt = rd_addr_r;
            end else begin
                slot_v_nxt = 1'b0;
            end
        end else if (k_rise && !slot_v_r) begin
            slot_v_nxt    = rd_pend_r;
            slot_addr_nxt = rd_addr_r;
        end
        case (out_st_r)
            OUT_IDLE: begin
                if (fire) begin
                    q_nxt        = rd_word(src_addr);
                    oe_nxt       = 1'b1;
                    sec_addr_nxt = {src_addr[P_ADDR_W-1:1],
                                    ~src_addr[0]};
                    out_st_nxt   = OUT_SECOND;
                end else if (oclk_rise) begin
                    oe_nxt = 1'b0;
                end
            end
            OUT_SECOND: begin
                if (ev_second) begin
                    q_nxt      = rd_word(sec_addr_r);
                    out_st_nxt = OUT_IDLE;
                end
            end
            default: begin
                out_st_nxt = OUT_IDLE;
                oe_nxt     = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_pend_r   <= 1'b0;
            rd_addr_r   <= '0;
            slot_v_r    <= 1'b0;
            slot_addr_r <= '0;
            sec_addr_r  <= '0;
            out_st_r    <= OUT_IDLE;
            o_q         <= '0;
            o_q_oe      <= 1'b0;
        end else begin
            rd_pend_r   <= rd_pend_nxt;
            rd_addr_r   <= rd_addr_nxt;
            slot_v_r    <= slot_v_nxt;
            slot_addr_r <= slot_addr_nxt;
            sec_addr_r  <= sec_addr_nxt;
            out_st_r    <= out_st_nxt;
            o_q         <= q_nxt;
            o_q_oe      <= oe_nxt;
        end
    end

    // Avalon-MM slave: one wait cycle per access
    logic [CNT_W-1:0]  rd_cnt_r, rd_cnt_nxt, wr_cnt_r, wr_cnt_nxt;
    logic              wait_nxt, req, take, ack;
    logic [AVS_DW-1:0] rdata_nxt, status;

    assign req  = i_avs_read | i_avs_write;
    assign take = req & o_avs_waitrequest;
    assign ack  = req & ~o_avs_waitrequest;
    assign status = {{(AVS_DW - 5){1'b0}},
                     (out_st_r != OUT_IDLE) | wd_v_r | wr_pend_r, post_v_r,
                     o_q_oe, dll_s, single_r};

    always_comb begin
        wait_nxt    = ~take;
        rdata_nxt   = o_avs_readdata;
        ctrl_en_nxt = ctrl_en_r;
        rd_cnt_nxt  = rd_cnt_r + {{(CNT_W - 1){1'b0}}, rd_cmd};
        wr_cnt_nxt  = wr_cnt_r + {{(CNT_W - 1){1'b0}}, wr_cmd};
        if (take) begin
            case (i_avs_address)
                REG_CTRL:   rdata_nxt = {{(AVS_DW - 1){1'b0}}, ctrl_en_r};
                REG_STATUS: rdata_nxt = status;
                REG_COUNT:  rdata_nxt = {wr_cnt_r, rd_cnt_r};
                default:    rdata_nxt = '0;
            endcase
        end
        if (ack && i_avs_write && i_avs_address == REG_CTRL
                && i_avs_byteenable[0]) begin
            ctrl_en_nxt = i_avs_writedata[CTRL_EN_BIT];
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= '0;
            ctrl_en_r         <= CTRL_EN_RESET;
            rd_cnt_r          <= '0;
            wr_cnt_r          <= '0;
        end else begin
            o_avs_waitrequest <= wait_nxt;
            o_avs_readdata    <= rdata_nxt;
            ctrl_en_r         <= ctrl_en_nxt;
            rd_cnt_r          <= rd_cnt_nxt;
            wr_cnt_r          <= wr_cnt_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);

    property p_rd_capture;
        rd_cmd |=> rd_pend_r && rd_addr_r == $past(addr_s);
    endproperty
    a_rd_capture: assert property (p_rd_capture)
        else $error("read address not captured");

    property p_burst_step;
        fire |=> sec_addr_r[0] != $past(src_addr[0])
              && o_q_oe && out_st_r == OUT_SECOND;
    endproperty
    a_burst_step: assert property (p_burst_step)
        else $error("second word address wrong");

    property p_dll_edge;
        fire && dll_s |-> oclkn_rise;
    endproperty
    a_dll_edge: assert property (p_dll_edge)
        else $error("first word not on negative output clock");

    property p_ddr1_edge;
        fire && !dll_s |-> oclk_rise;
    endproperty
    a_ddr1_edge: assert property (p_ddr1_edge)
        else $error("first word not on positive output clock");

    property p_second_word;
        out_st_r == OUT_SECOND && ev_second
            |=> o_q == $past(rd_word(sec_addr_r)) && out_st_r == OUT_IDLE;
    endproperty
    a_second_word: assert property (p_second_word)
        else $error("second word not driven");

    property p_float;
        out_st_r == OUT_IDLE && !fire && oclk_rise |=> !o_q_oe;
    endproperty
    a_float: assert property (p_float)
        else $error("outputs not floated");

    property p_no_spurious;
        $rose(o_q_oe) |-> $past(fire);
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("outputs driven without a burst");

    property p_ctrl_sample;
        !k_rise |=> $stable(wr_addr_r) && $stable(rd_addr_r);
    endproperty
    a_ctrl_sample: assert property (p_ctrl_sample)
        else $error("command sampled off positive rise");

    property p_post_load;
        kn_rise && wd_v_r |=> post_v_r && post_w1_r == $past(d_s)
                             && post_m1_r == ~$past(bsel_n_s);
    endproperty
    a_post_load: assert property (p_post_load)
        else $error("second write word lost");

    property p_bus_wait;
        req && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("bus answer late");

    c_read:   cover property (fire ##[1:40] ev_second);
    c_commit: cover property (commit);
    c_bypass: cover property (fire && post_v_r && src_addr == post_addr_r);
    c_bus:    cover property (ack && i_avs_read);

endmodule // dbp_sram_port

`default_nettype wire

/* File: dbp_pkg.sv */
/*
 * Constants and types of the two-word burst DDR SRAM port.
 * Assumes a single 100 MHz system clock samples every pin of the link.
 */
`default_nettype none

package dbp_pkg;
    localparam int DATA_W    = 18;
    localparam int BYTE_W    = 9;
    localparam int NUM_BYTES = 2;
    localparam int ADDR_W    = 20;
    localparam int AVS_AW    = 4;
    localparam int AVS_DW    = 32;

    // Register byte offsets
    localparam logic [AVS_AW-1:0] REG_CTRL   = 4'h0;
    localparam logic [AVS_AW-1:0] REG_STATUS = 4'h4;
    localparam logic [AVS_AW-1:0] REG_COUNT  = 4'h8;

    // Field positions and reset values
    localparam int CTRL_EN_BIT   = 0;
    localparam int ST_SINGLE_BIT = 0;
    localparam int ST_DLL_BIT    = 1;
    localparam int ST_OE_BIT     = 2;
    localparam int ST_POST_BIT   = 3;
    localparam int ST_BUSY_BIT   = 4;
    localparam int CNT_W         = 16;
    localparam logic CTRL_EN_RESET = 1'h1;

    // Strap capture after reset release
    localparam logic [1:0] STRAP_AT   = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;

    typedef enum logic [1:0] {
        OUT_IDLE   = 2'b01,
        OUT_SECOND = 2'b10
    } dbp_out_state_t;
endpackage

`default_nettype wire

/* File: dbp_ctrl_model.sv */
/*
 * Memory controller model on the link side of the SRAM port.
 * Assumes the bench calls step once per link cycle and reads the logs.
 */
`default_nettype none

module dbp_ctrl_model
    import dbp_pkg::*;
#(
    parameter int P_ADDR_W = 6
) (
    input  wire logic                 i_clock,
    output var  logic                 o_k,
    output var  logic                 o_dir_read,
    output var  logic                 o_load_strobe_n,
    output var  logic [NUM_BYTES-1:0] o_byte_write_select_n,
    output var  logic [P_ADDR_W-1:0]  o_addr,
    output var  logic [DATA_W-1:0]    o_d,
    input  wire logic [DATA_W-1:0]    i_q,
    input  wire logic                 i_q_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [DATA_W-1:0]    log_q[$];
    logic                 log_oe[$];
    // Second write word waits for the next K rise to pass
    logic                 wd_hold = 1'b0;
    logic [NUM_BYTES-1:0] bw_hold = '1;
    logic [DATA_W-1:0]    d1_hold = '0;

    initial begin
        o_dir_read = 1'b1;
        o_load_strobe_n = 1'b1;
        o_byte_write_select_n = 2'h3;
        o_addr = '0;
        o_d = '0;
    end

    // Free running link clock, 125 ns, kept off the system clock edges
    initial begin
        o_k = 1'b0;
        #2;
        forever #62.5 o_k = ~o_k;
    end

    // Midway between link edges: log outputs
    task automatic settle();
        repeat (4) @(posedge i_clock);
        log_q.push_back(i_q);
        log_oe.push_back(i_q_oe);
    endtask

    // Command for the next K rise; write word0 for the next K rise,
    // word1 for the K_n rise after it
    task automatic step(input logic load_n, input logic rd,
                        input logic [P_ADDR_W-1:0] a, input logic wd,
                        input logic [NUM_BYTES-1:0] bw,
                        input logic [DATA_W-1:0] d0,
                        input logic [DATA_W-1:0] d1);
        @(posedge o_k);
        settle();
        o_load_strobe_n <= load_n;
        o_dir_read <= rd;
        o_addr <= load_n ? ~o_addr : a;
        o_byte_write_select_n <= wd_hold ? bw_hold : ~o_byte_write_select_n;
        o_d <= wd_hold ? d1_hold : ~o_d;
        @(negedge o_k);
        settle();
        o_byte_write_select_n <= wd ? bw : ~o_byte_write_select_n;
        o_d <= wd ? d0 : ~o_d;
        wd_hold = wd;
        bw_hold = bw;
        d1_hold = d1;
    endtask
endmodule // dbp_ctrl_model

`default_nettype wire

/* File: dbp_sram_port_tb.sv */
/*
 * Bench of the SRAM port: link traffic in three clock modes, registers.
 * Assumes dbp_ctrl_model as the controller on the link.
 */
`default_nettype none

module dbp_sram_port_tb
    import dbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [1:0]  op;
        logic [5:0]  a;
        logic [1:0]  bw;
        logic [17:0] d0;
        logic [17:0] d1;
    } dbp_tb_row_t;
    localparam int N_ROWS = 14;
    // Op 1 write, 2 read with expected words, 0 idle
    localparam dbp_tb_row_t ROWS [N_ROWS] = '{
        '{2'h1, 6'h04, 2'h0, 18'h12345, 18'h2abcd},
        '{2'h1, 6'h09, 2'h0, 18'h3ffff, 18'h00001},
        '{2'h0, 6'h00, 2'h0, 18'h0, 18'h0},
        '{2'h2, 6'h04, 2'h0, 18'h12345, 18'h2abcd},
        '{2'h2, 6'h09, 2'h0, 18'h3ffff, 18'h00001},
        '{2'h2, 6'h08, 2'h0, 18'h00001, 18'h3ffff},
        '{2'h0, 6'h00, 2'h0, 18'h0, 18'h0},
        '{2'h1, 6'h04, 2'h1, 18'h00000, 18'h3ffff},
        '{2'h2, 6'h04, 2'h0, 18'h00145, 18'h3ffcd},
        '{2'h0, 6'h00, 2'h0, 18'h0, 18'h0},
        '{2'h1, 6'h04, 2'h3, 18'h11111, 18'h11111},
        '{2'h2, 6'h04, 2'h0, 18'h00145, 18'h3ffcd},
        '{2'h0, 6'h00, 2'h0, 18'h0, 18'h0},
        '{2'h0, 6'h00, 2'h0, 18'h0, 18'h0}
    };

    logic              clock = 1'b0;
    logic              arst_n, pll_n, single, k, dir, load_n, av_rd, av_wr;
    logic [1:0]        bsel_n;
    logic [5:0]        addr;
    logic [DATA_W-1:0] d, q;
    logic              q_oe, wait_req;
    logic [3:0]        av_addr;
    logic [31:0]       av_wdata, av_rdata;
    int                n_fail = 0;
    int                check_count = 0;
    int                cycles = 0;

    always #5 clock = ~clock;

    dbp_ctrl_model #(.P_ADDR_W(6)) u_ctl (
        .i_clock(clock), .o_k(k), .o_dir_read(dir), .o_load_strobe_n(load_n),
        .o_byte_write_select_n(bsel_n), .o_addr(addr), .o_d(d), .i_q(q),
        .i_q_oe(q_oe));

    // Both output clocks tied high strap single clock mode
    dbp_sram_port #(.P_ADDR_W(6)) u_dut (
        .i_clock(clock), .i_arst_n(arst_n), .i_k(k), .i_k_n(~k),
        .i_c(single ? 1'b1 : k), .i_c_n(single ? 1'b1 : ~k),
        .i_pll_disable_n(pll_n), .i_dir_read(dir), .i_load_strobe_n(load_n),
        .i_byte_write_select_n(bsel_n), .i_addr(addr), .i_d(d), .o_q(q),
        .o_q_oe(q_oe), .i_avs_address(av_addr), .i_avs_read(av_rd),
        .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
        .i_avs_byteenable(4'hf), .o_avs_readdata(av_rdata),
        .o_avs_waitrequest(wait_req));

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_q(input string nm, input logic [17:0] got,
                         input logic [17:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] got,
                           input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Register access held until waitrequest is seen low
    task automatic av(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock);
        av_rd <= !wr;
        av_wr <= wr;
        av_addr <= a;
        av_wdata <= wd;
        do begin
            @(posedge clock);
        end while (wait_req !== 1'b0);
        rd = av_rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        int m, i, j, base;
        dbp_tb_row_t r, p;
        logic [31:0] rd;
        arst_n = 1'b0;
        pll_n = 1'b1;
        single = 1'b0;
        av_rd = 1'b0;
        av_wr = 1'b0;
        av_addr = 4'h0;
        av_wdata = 32'h0;
        for (m = 0; m < 3; m++) begin
            pll_n <= (m != 1);
            single <= (m == 2);
            arst_n <= 1'b0;
            repeat (2) @(posedge clock);
            arst_n <= 1'b1;
            repeat (8) @(posedge clock);
            av(1'b0, REG_CTRL, 32'h0, rd);
            chk_reg("ctrl", rd, {31'h0, CTRL_EN_RESET});
            av(1'b0, REG_STATUS, 32'h0, rd);
            chk_reg("mode", rd, {30'h0, pll_n, single});
            base = u_ctl.log_q.size();
            for (i = 0; i < N_ROWS + 3; i++) begin
                r = (i < N_ROWS) ? ROWS[i] : '0;
                p = (i > 0 && i <= N_ROWS) ? ROWS[i-1] : '0;
                u_ctl.step(r.op == 2'h0, r.op != 2'h1, r.a, p.op == 2'h1,
                           p.bw, p.d0, p.d1);
            end
            for (i = 0; i < N_ROWS; i++) begin
                if (ROWS[i].op == 2'h2) begin
                    j = base + 2 * i + 4 + int'(m != 1);
                    chk_q("word0", u_ctl.log_q[j], ROWS[i].d0);
                    chk_q("word1", u_ctl.log_q[j+1], ROWS[i].d1);
                    chk_q("oe_on", {17'h0, u_ctl.log_oe[j]}, 18'h1);
                end
            end
            chk_q("oe_off", {17'h0, u_ctl.log_oe[base+30]}, 18'h0);
            av(1'b1, REG_CTRL, 32'h0, rd);
            base = u_ctl.log_q.size();
            u_ctl.step(1'b0, 1'b1, 6'h04, 1'b0, 2'h0, 18'h0, 18'h0);
            repeat (3) u_ctl.step(1'b1, 1'b1, 6'h0, 1'b0, 2'h0, 18'h0, 18'h0);
            chk_q("oe_refused", {17'h0, u_ctl.log_oe[base+5]}, 18'h0);
            av(1'b0, REG_COUNT, 32'h0, rd);
            chk_reg("count", rd, 32'h00040005);
            av(1'b0, 4'hc, 32'h0, rd);
            chk_reg("unmapped", rd, 32'h0);
            $display("mode %0d done, mismatches %0d", m, n_fail);
        end
        test_done();
    end
endmodule // dbp_sram_port_tb

`default_nettype wire
